// file: common/lam_pkg.sv
// Package of constants for the link alarm monitor
package lam_pkg;

  // ==========================================================================
  // Bus and map
  localparam int         ADDR_W          = 4;       // Word address width
  localparam int         DATA_W          = 32;      // Bus data width
  localparam int         NUM_LANES       = 8;       // Serializer lanes watched
  localparam int         NUM_SRC         = 6;       // Alarm source types
  localparam int         CLK_W           = 4;       // Compared internal clock bits

  // Byte offsets of registers (word index = offset / 4)
  localparam logic [5:0] OFF_STATUS      = 6'h00;   // Alarm event flags, W1C
  localparam logic [5:0] OFF_MASK        = 6'h04;   // Alarm suppress bits
  localparam logic [5:0] OFF_CTRL        = 6'h08;   // Link enable, pin select
  localparam logic [5:0] OFF_SUMMARY     = 6'h0c;   // Combined alarm indication
  localparam logic [5:0] OFF_LANE        = 6'h10;   // Lane FIFO error flags, W1C
  localparam logic [5:0] OFF_LANE_MASK   = 6'h14;   // Lane FIFO suppress bits
  localparam logic [5:0] OFF_LIVE        = 6'h18;   // Filtered pin levels

  // ==========================================================================
  // Status bit positions
  localparam int         BIT_CPLL        = 0;       // Converter PLL unlock
  localparam int         BIT_SPLL        = 1;       // Serializer PLL unlock
  localparam int         BIT_LINK        = 2;       // Link not transmitting
  localparam int         BIT_SYSREF      = 3;       // Internal clocks realigned
  localparam int         BIT_CLK         = 4;       // Clock upset
  localparam int         BIT_FIFO        = 5;       // Any lane FIFO error

  // Control bit positions
  localparam int         CTRL_LINK_EN    = 0;       // Serial link enable
  localparam int         CTRL_PIN_ALARM  = 1;       // Pin shows alarm
  localparam int         CTRL_PD_A       = 2;       // Channel A powerdown
  localparam int         CTRL_PD_B       = 3;       // Channel B powerdown

  // ==========================================================================
  // Reset values
  localparam logic [NUM_SRC-1:0]   RST_STATUS = 6'h00;
  localparam logic [NUM_SRC-1:0]   RST_MASK   = 6'h3f;  // All masked at start
  localparam logic [3:0]           RST_CTRL   = 4'h0;
  localparam logic [NUM_LANES-1:0] RST_LANE_M = 8'h00;
  localparam logic [DATA_W-1:0]    UNMAPPED   = 32'hdead0bad; // Arbitrary

  // Cycles a read waits before answering (read data from a register)
  localparam int         RD_WAIT_CYC     = 1;

endpackage

// file: verilog/lam_sync3.sv
// Three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module lam_sync3 #(
  parameter int W = 1                          // Number of bits
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Data
  input  wire logic [W-1:0] async_in,          // From outside the clock domain
  output logic      [W-1:0] sync_out           // Filtered level
);

  logic [W-1:0] s1_reg;                        // Metastability catcher
  logic [W-1:0] s2_reg;                        // Second stage
  logic [W-1:0] s3_reg;                        // Third stage
  logic [W-1:0] out_reg;                       // Accepted level
  logic [W-1:0] out_next;

  // ==========================================================================
  // Accept a change only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : out_reg[i];
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      out_reg <= '0;
    end else begin
      s1_reg  <= async_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;

endmodule

`default_nettype wire

// file: verilog/lam_monitor.sv
// Alarm monitor for a converter with a serial transmit link
// Function
// - Detect six alarm source types
// - Each source sets its own status bit
// - Flags stick until host writes one
// - Unmasked flags reach combined indication
// - Pin high on alarm when selected
// - Channel clock mismatch sets clock upset flag; compared only while link enabled
// - Powerdown exit may set clock flag; host clears
// - Lane FIFO pointer upset sets lane flag
// - Link enable toggle resets FIFO logic
// - Link disabled: reset, serializers off, gated
//
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module lam_monitor
  import lam_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]    avs_address,       // Word address
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [DATA_W-1:0]    avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [DATA_W-1:0]    avs_readdata,
  output logic                      avs_waitrequest,
  // Alarm sources from the converter core
  input  wire logic                 cpll_unlocked,     // Async level
  input  wire logic                 spll_unlocked,     // Async level
  input  wire logic                 link_in_data_state, // Same clock
  input  wire logic                 sysref_realign,    // Same clock pulse
  input  wire logic [CLK_W-1:0]     chan_a_clk_phase,  // Same clock
  input  wire logic [CLK_W-1:0]     chan_b_clk_phase,  // Same clock
  input  wire logic                 half_rate_tick,    // DEVICE_CLOCK_INPUT/2 strobe
  input  wire logic [NUM_LANES-1:0] lane_fifo_ptr_err, // Same clock pulses
  input  wire logic                 global_powerdown_pin, // Async level
  // Link block and channel powerdown control
  output logic                      link_block_reset,  // Held while disabled
  output logic                      serializer_powerdown,
  output logic                      link_clock_gate_en,
  output logic                      fifo_logic_reset,  // High while disabled and one cycle after re-enable
  output logic                      chan_a_powerdown,
  output logic                      chan_b_powerdown,
  // Alarm outputs
  output logic                      calib_state_output_pin,
  output logic                      alarm_irq
);

  // ==========================================================================
  // Synchronised pins
  logic [2:0] pin_sync;                                // Filtered async inputs

  lam_sync3 #(.W(3)) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({global_powerdown_pin, spll_unlocked, cpll_unlocked}),
    .sync_out (pin_sync)
  );

  // ==========================================================================
  // Register state
  logic [NUM_SRC-1:0]   alarm_event_flags_reg,   alarm_event_flags_next;
  logic [NUM_SRC-1:0]   alarm_suppress_bits_reg, alarm_suppress_bits_next;
  logic [NUM_LANES-1:0] lane_fifo_error_flags_reg, lane_fifo_error_flags_next;
  logic [NUM_LANES-1:0] lane_mask_reg,           lane_mask_next;
  logic [3:0]           ctrl_reg,                ctrl_next;
  logic                 pd_prev_reg,             pd_prev_next;   // Pin history
  logic                 fifo_rst_reg,            fifo_rst_next;  // Re-enable pulse
  logic [DATA_W-1:0]    rdata_reg,               rdata_next;
  logic                 rd_pend_reg,             rd_pend_next;   // Read wait state

  // Decode helpers
  logic [5:0]           byte_addr;                     // Byte address
  logic                 wr_go;                         // Write accepted now
  logic                 link_en;                       // serial_link_enable
  logic                 clk_mismatch;                  // Channel compare
  logic [NUM_SRC-1:0]   src_evt;                       // Event per source
  logic [NUM_SRC-1:0]   w1c_mask;                      // Status bits cleared
  logic [NUM_LANES-1:0] lane_w1c;                      // Lane bits cleared
  logic [NUM_LANES-1:0] lane_evt;                      // Lane events
  logic                 alarm_summary;                 // Combined indication

  assign byte_addr = {avs_address, 2'b00};
  assign wr_go     = avs_write;                        // Writes take one cycle
  assign link_en   = ctrl_reg[CTRL_LINK_EN];

  // ==========================================================================
  // Event detection
  always_comb begin
    // Compare only on a half-rate strobe while the link is enabled
    clk_mismatch = half_rate_tick && link_en
                   && (chan_a_clk_phase != chan_b_clk_phase);
    // Lane errors only count while the link runs; disabled link is in reset
    lane_evt     = link_en ? lane_fifo_ptr_err : '0;
    src_evt                = '0;
    src_evt[BIT_CPLL]      = pin_sync[0];
    src_evt[BIT_SPLL]      = pin_sync[1];
    src_evt[BIT_LINK]      = link_en && !link_in_data_state;
    src_evt[BIT_SYSREF]    = sysref_realign;
    // Leaving global powerdown may disturb clocks, so flag it too
    src_evt[BIT_CLK]       = clk_mismatch
                             || (pd_prev_reg && !pin_sync[2]);
    src_evt[BIT_FIFO]      = |lane_evt;
  end

  // ==========================================================================
  // Write-one-to-clear masks (lane 0 byte enable gates the low byte)
  always_comb begin
    w1c_mask = '0;
    lane_w1c = '0;
    if (wr_go && avs_byteenable[0]) begin
      if (byte_addr == OFF_STATUS) w1c_mask = avs_writedata[NUM_SRC-1:0];
      if (byte_addr == OFF_LANE)   lane_w1c = avs_writedata[NUM_LANES-1:0];
    end
  end

  // ==========================================================================
  // Next state of flags and controls; set wins over clear
  always_comb begin
    alarm_event_flags_next     = (alarm_event_flags_reg & ~w1c_mask)
                                 | src_evt;
    lane_fifo_error_flags_next = (lane_fifo_error_flags_reg & ~lane_w1c)
                                 | lane_evt;
    alarm_suppress_bits_next   = alarm_suppress_bits_reg;
    lane_mask_next             = lane_mask_reg;
    ctrl_next                  = ctrl_reg;
    pd_prev_next               = pin_sync[2];
    if (wr_go && avs_byteenable[0]) begin
      unique case (byte_addr)
        OFF_MASK:      alarm_suppress_bits_next = avs_writedata[NUM_SRC-1:0];
        OFF_LANE_MASK: lane_mask_next           = avs_writedata[NUM_LANES-1:0];
        OFF_CTRL:      ctrl_next                = avs_writedata[3:0];
        default: begin
          // Other addresses hold nothing writable
        end
      endcase
    end
    // FIFO reset pulse on the rising edge of the link enable
    fifo_rst_next = !link_en && ctrl_next[CTRL_LINK_EN];
  end

  // ==========================================================================
  // Combined indication: any unmasked flag
  always_comb begin
    alarm_summary = |(alarm_event_flags_reg & ~alarm_suppress_bits_reg)
                    || |(lane_fifo_error_flags_reg & ~lane_mask_reg);
  end

  // ==========================================================================
  // Read path: one wait cycle, data from a register
  always_comb begin
    rd_pend_next = avs_read && !rd_pend_reg;
    rdata_next   = rdata_reg;
    if (avs_read && !rd_pend_reg) begin
      rdata_next = '0;
      unique case (byte_addr)
        OFF_STATUS:    rdata_next[NUM_SRC-1:0]   = alarm_event_flags_reg;
        OFF_MASK:      rdata_next[NUM_SRC-1:0]   = alarm_suppress_bits_reg;
        OFF_CTRL:      rdata_next[3:0]           = ctrl_reg;
        OFF_SUMMARY:   rdata_next[0]             = alarm_summary;
        OFF_LANE:      rdata_next[NUM_LANES-1:0] = lane_fifo_error_flags_reg;
        OFF_LANE_MASK: rdata_next[NUM_LANES-1:0] = lane_mask_reg;
        OFF_LIVE:      rdata_next[2:0]           = pin_sync;
        default:       rdata_next                = UNMAPPED;
      endcase
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_event_flags_reg     <= RST_STATUS;
      alarm_suppress_bits_reg   <= RST_MASK;
      lane_fifo_error_flags_reg <= '0;
      lane_mask_reg             <= RST_LANE_M;
      ctrl_reg                  <= RST_CTRL;
      pd_prev_reg               <= 1'b0;
      fifo_rst_reg              <= 1'b0;
      rdata_reg                 <= '0;
      rd_pend_reg               <= 1'b0;
    end else begin
      alarm_event_flags_reg     <= alarm_event_flags_next;
      alarm_suppress_bits_reg   <= alarm_suppress_bits_next;
      lane_fifo_error_flags_reg <= lane_fifo_error_flags_next;
      lane_mask_reg             <= lane_mask_next;
      ctrl_reg                  <= ctrl_next;
      pd_prev_reg               <= pd_prev_next;
      fifo_rst_reg              <= fifo_rst_next;
      rdata_reg                 <= rdata_next;
      rd_pend_reg               <= rd_pend_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata           = rdata_reg;
  assign avs_waitrequest        = avs_read && !rd_pend_reg;
  assign link_block_reset       = !link_en;
  assign serializer_powerdown   = !link_en;
  assign link_clock_gate_en     = link_en;
  assign fifo_logic_reset       = fifo_rst_reg || !link_en;
  assign chan_a_powerdown       = ctrl_reg[CTRL_PD_A];
  assign chan_b_powerdown       = ctrl_reg[CTRL_PD_B];
  assign calib_state_output_pin = ctrl_reg[CTRL_PIN_ALARM] && alarm_summary;
  assign alarm_irq              = alarm_summary;

  // ==========================================================================
  // Assertions
  sequence s_upset;
    half_rate_tick && link_en && (chan_a_clk_phase != chan_b_clk_phase);
  endsequence

  property p_clk_upset;
    @(posedge clk) disable iff (!reset_n)
    s_upset |=> alarm_event_flags_reg[BIT_CLK];
  endproperty
  a_clk_upset: assert property (p_clk_upset) else $error("clock upset not flagged");

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
    alarm_event_flags_reg[BIT_SYSREF] && !(wr_go && byte_addr == OFF_STATUS)
    |=> alarm_event_flags_reg[BIT_SYSREF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status flag lost");

  property p_w1c;
    @(posedge clk) disable iff (!reset_n)
    wr_go && avs_byteenable[0] && byte_addr == OFF_STATUS
    && avs_writedata[BIT_SYSREF] && !sysref_realign
    |=> !alarm_event_flags_reg[BIT_SYSREF];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_sysref_set;
    @(posedge clk) disable iff (!reset_n)
    sysref_realign |=> alarm_event_flags_reg[BIT_SYSREF];
  endproperty
  a_sysref_set: assert property (p_sysref_set) else $error("sysref not flagged");

  property p_lane;
    @(posedge clk) disable iff (!reset_n)
    link_en && lane_fifo_ptr_err[0]
    |=> lane_fifo_error_flags_reg[0] && alarm_event_flags_reg[BIT_FIFO];
  endproperty
  a_lane: assert property (p_lane) else $error("lane error not flagged");

  property p_mask;
    @(posedge clk) disable iff (!reset_n)
    (&alarm_suppress_bits_reg) && (&lane_mask_reg) |-> !alarm_irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked alarm indicated");

  property p_pin;
    @(posedge clk) disable iff (!reset_n)
    ctrl_reg[CTRL_PIN_ALARM] |-> calib_state_output_pin == alarm_irq;
  endproperty
  a_pin: assert property (p_pin) else $error("pin does not follow alarm");

  // Clearing the last unmasked flag, with no new event, drops the indication
  property p_clear_drop;
    @(posedge clk) disable iff (!reset_n)
    w1c_mask != '0 && src_evt == '0
    && (alarm_event_flags_reg & ~alarm_suppress_bits_reg & ~w1c_mask) == '0
    && (lane_fifo_error_flags_reg & ~lane_mask_reg) == '0
    |=> !alarm_irq;
  endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("indication stuck");

  property p_fifo_rst;
    @(posedge clk) disable iff (!reset_n)
    !link_en ##1 link_en |-> fifo_logic_reset ##1 !fifo_logic_reset;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("no fifo reset on enable");

  property p_disabled;
    @(posedge clk) disable iff (!reset_n)
    !link_en |-> link_block_reset && serializer_powerdown && !link_clock_gate_en;
  endproperty
  a_disabled: assert property (p_disabled) else $error("link not held off");

endmodule

`default_nettype wire

// file: tb/lam_host_model.sv
// Host software model: Avalon-MM master on the alarm monitor register port
`timescale 1ns/1ns
`default_nettype none

module lam_host_model
  import lam_pkg::*;
(
  // Clock
  input  wire logic              clk,
  // Avalon-MM master side
  output logic      [ADDR_W-1:0] avs_address,
  output logic                   avs_read,
  output logic                   avs_write,
  output logic      [DATA_W-1:0] avs_writedata,
  output logic      [3:0]        avs_byteenable,
  input  wire logic [DATA_W-1:0] avs_readdata,
  input  wire logic              avs_waitrequest
);
  // ==========================================================================
  // Idle bus
  // Bus idle from time zero
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'hf;
  end

  // ==========================================================================
  // Bus cycles
  // Write, held until waitrequest is seen low; a one clears a flag
  task automatic bus_write(input logic [5:0] off, input logic [DATA_W-1:0] d);
    avs_address   <= off[5:2];
    avs_writedata <= d;
    avs_write     <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write     <= 1'b0;
    // Released data shows the inverse so stale values never look valid
    avs_writedata <= ~d;
    @(posedge clk);
  endtask

  // Read, data taken at the edge where waitrequest is low
  task automatic bus_read(input logic [5:0] off, output logic [DATA_W-1:0] d);
    avs_address <= off[5:2];
    avs_read    <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read    <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_link_alarm_monitor.sv
// Self-checking testbench for the link alarm monitor
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_link_alarm_monitor
  import lam_pkg::*;
;
  // ==========================================================================
  // Signals
  logic                 clk = 1'b0;           // 250 MHz
  logic                 reset_n = 1'b0;       // Async, active low
  logic [ADDR_W-1:0]    avs_address;
  logic                 avs_read;
  logic                 avs_write;
  logic [DATA_W-1:0]    avs_writedata;
  logic [3:0]           avs_byteenable;
  logic [DATA_W-1:0]    avs_readdata;
  logic                 avs_waitrequest;
  logic                 cpll_unlocked = 1'b0;
  logic                 spll_unlocked = 1'b0;
  logic                 link_in_data_state = 1'b1;
  logic                 sysref_realign = 1'b0;
  logic [CLK_W-1:0]     chan_a_clk_phase = 4'ha;
  logic [CLK_W-1:0]     chan_b_clk_phase = 4'ha;
  logic                 half_rate_tick = 1'b0;
  logic [NUM_LANES-1:0] lane_fifo_ptr_err = 8'h00;
  logic                 global_powerdown_pin = 1'b0;
  logic [7:0]           pins;                 // Control and alarm outputs
  int                   mismatches = 0;
  int                   n_tests = 0;
  int                   cycles = 0;
  int                   fifo_pulses = 0;      // FIFO resets seen with link up

  assign pins = {lam_monitor_inst.link_block_reset, lam_monitor_inst.serializer_powerdown,
                 lam_monitor_inst.link_clock_gate_en, lam_monitor_inst.fifo_logic_reset,
                 lam_monitor_inst.chan_a_powerdown, lam_monitor_inst.chan_b_powerdown,
                 lam_monitor_inst.calib_state_output_pin, lam_monitor_inst.alarm_irq};

  // ==========================================================================
  // Instances
  lam_monitor lam_monitor_inst (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpll_unlocked(cpll_unlocked), .spll_unlocked(spll_unlocked),
    .link_in_data_state(link_in_data_state), .sysref_realign(sysref_realign),
    .chan_a_clk_phase(chan_a_clk_phase), .chan_b_clk_phase(chan_b_clk_phase),
    .half_rate_tick(half_rate_tick), .lane_fifo_ptr_err(lane_fifo_ptr_err),
    .global_powerdown_pin(global_powerdown_pin), .link_block_reset(),
    .serializer_powerdown(), .link_clock_gate_en(), .fifo_logic_reset(),
    .chan_a_powerdown(), .chan_b_powerdown(), .calib_state_output_pin(), .alarm_irq());

  lam_host_model lam_host_model_inst (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ==========================================================================
  // Clock, half-rate strobe and timeout
  always #2 clk = ~clk;
  always @(posedge clk) half_rate_tick <= ~half_rate_tick;
  // Count re-enable resets: FIFO reset while the link clock runs
  always @(posedge clk) begin
    if (lam_monitor_inst.fifo_logic_reset && lam_monitor_inst.link_clock_gate_en) begin
      fifo_pulses++;
    end
  end
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic wr(input logic [5:0] off, input logic [DATA_W-1:0] d);
    lam_host_model_inst.bus_write(off, d);
  endtask

  task automatic rd_cmp(input logic [5:0] off, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] got;
    lam_host_model_inst.bus_read(off, got);
    `CHK("register read", e, got)
  endtask

  // Outputs looked at on the falling edge, where they have settled
  task automatic chk_pins(input logic [7:0] e);
    @(negedge clk);
    `CHK("output pins", e, pins)
    @(posedge clk);
  endtask

  // Drive one alarm source active or idle
  task automatic set_src(input int s, input logic v);
    case (s)
      0: cpll_unlocked <= v;
      1: spll_unlocked <= v;
      2: link_in_data_state <= ~v;
      3: sysref_realign <= v;
      4: chan_b_clk_phase <= v ? 4'h5 : 4'ha;
      default: lane_fifo_ptr_err <= v ? 8'h81 : 8'h00;
    endcase
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    rd_cmp(OFF_STATUS, 32'h0);
    rd_cmp(OFF_MASK, {26'h0, RST_MASK});
    rd_cmp(OFF_CTRL, 32'h0);
    rd_cmp(6'h1c, UNMAPPED);
    chk_pins(8'hd0);
  endtask

  task automatic test_enable;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_STATUS, 32'h10);
    rd_cmp(OFF_STATUS, 32'h0);
    chk_pins(8'h20);
    `CHK("fifo reset pulses", 1, fifo_pulses)
  endtask

  // Each source alone; clock mismatch lasts one half-rate tick only
  task automatic test_sources;
    for (int s = 0; s < NUM_SRC; s++) begin
      set_src(s, 1'b1);
      repeat (s < 3 ? 8 : 2) @(posedge clk);
      set_src(s, 1'b0);
      repeat (8) @(posedge clk);
      rd_cmp(OFF_STATUS, 32'h1 << s);
      if (s == BIT_FIFO) begin
        // Lane flags are unmasked after reset, so they raise the indication
        chk_pins(8'h21);
        rd_cmp(OFF_LANE, 32'h81);
        wr(OFF_LANE, 32'h81);
      end
      wr(OFF_STATUS, 32'h1 << s);
      rd_cmp(OFF_STATUS, 32'h0);
    end
  endtask

  task automatic test_mask;
    wr(OFF_MASK, 32'h37);
    set_src(BIT_SYSREF, 1'b1);
    @(posedge clk);
    set_src(BIT_SYSREF, 1'b0);
    repeat (2) @(posedge clk);
    chk_pins(8'h21);
    rd_cmp(OFF_SUMMARY, 32'h1);
    wr(OFF_CTRL, 32'h3);
    chk_pins(8'h23);
    wr(OFF_LANE_MASK, 32'hff);
    rd_cmp(OFF_LANE_MASK, 32'hff);
    wr(OFF_MASK, 32'h3f);
    chk_pins(8'h20);
    wr(OFF_MASK, 32'h37);
    wr(OFF_STATUS, 32'h8);
    chk_pins(8'h20);
    rd_cmp(OFF_SUMMARY, 32'h0);
  endtask

  task automatic test_powerdown_exit;
    global_powerdown_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rd_cmp(OFF_LIVE, 32'h4);
    global_powerdown_pin <= 1'b0;
    repeat (8) @(posedge clk);
    rd_cmp(OFF_STATUS, 32'h10);
    wr(OFF_STATUS, 32'h10);
    rd_cmp(OFF_STATUS, 32'h0);
  endtask

  // Disabled link ignores lane and link events; re-enable restarts cleanly
  task automatic test_link_toggle;
    wr(OFF_CTRL, 32'hc);
    chk_pins(8'hdc);
    set_src(BIT_FIFO, 1'b1);
    set_src(BIT_LINK, 1'b1);
    repeat (2) @(posedge clk);
    set_src(BIT_FIFO, 1'b0);
    set_src(BIT_LINK, 1'b0);
    rd_cmp(OFF_LANE, 32'h0);
    rd_cmp(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    chk_pins(8'h20);
    `CHK("fifo reset pulses", 2, fifo_pulses)
  endtask

  // ==========================================================================
  // Verdict and main sequence
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    test_reset();
    test_enable();
    test_sources();
    test_mask();
    test_powerdown_exit();
    test_link_toggle();
    print_verdict();
  end
endmodule
`default_nettype wire
